//--- ctb_pkg.sv
// Purpose: Shared constants for the transmit buffer flag and abort block
// Assumes: 8-bit register port, 4-bit word address
// Notes:   Offsets, field positions and reset values are named here once

`default_nettype none

package ctb_pkg;

  // ==========================================================================
  // Register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MAX_BUF = 4;   // Two event groups must fit one byte

  // ==========================================================================
  // Register offsets (word addresses)
  localparam logic [ADDR_W-1:0] OFS_TX_FLAGS  = 4'h0;  // tx_buffer_empty_flags, W1C
  localparam logic [ADDR_W-1:0] OFS_TX_IER    = 4'h1;  // tx_empty_irq_enables, RW
  localparam logic [ADDR_W-1:0] OFS_TX_ARQ    = 4'h2;  // tx_abort_requests, W1S
  localparam logic [ADDR_W-1:0] OFS_TX_AAK    = 4'h3;  // tx_abort_acks, RO
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 4'h4;  // Mode control, RW
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 4'h5;  // Mode status, RO
  localparam logic [ADDR_W-1:0] OFS_EVT_STAT  = 4'h6;  // Sticky events, RO
  localparam logic [ADDR_W-1:0] OFS_EVT_CLR   = 4'h7;  // Event clear, WO
  localparam logic [ADDR_W-1:0] OFS_EVT_EN    = 4'h8;  // Event enables, RW

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_INIT_REQ_BIT = 0;   // init_mode_request
  localparam int unsigned CTRL_LISTEN_BIT   = 1;   // listen-only mode
  localparam int unsigned STAT_INIT_ACK_BIT = 0;   // init_mode_ack
  localparam int unsigned STAT_INIT_ACT_BIT = 1;   // both request and ack set
  localparam int unsigned EVT_SENT_LSB      = 0;   // Buffer sent, one bit per buffer
  localparam int unsigned EVT_ABORT_LSB     = 4;   // Buffer aborted, one bit per buffer

  // ==========================================================================
  // Reset values
  localparam logic [DATA_W-1:0] TX_FLAGS_RST = 8'h07;  // All buffers empty
  localparam logic [DATA_W-1:0] TX_IER_RST   = 8'h00;
  localparam logic [DATA_W-1:0] TX_ARQ_RST   = 8'h00;
  localparam logic [DATA_W-1:0] TX_AAK_RST   = 8'h00;
  localparam logic [DATA_W-1:0] CTRL_RST     = 8'h01;  // Comes up in init mode
  localparam logic [DATA_W-1:0] EVT_RST      = 8'h00;

endpackage : ctb_pkg

`default_nettype wire

//--- ctb_tx_flags.sv
// Purpose: Transmit buffer empty flags, interrupt enables, abort requests and acks
// Assumes: One clock; register port with read data one cycle after the strobe
// Notes:   Transmit engine reports per-buffer busy, success and failure
//
// Summary of operation
// - Outside init and listen-only mode, writing 1 clears an empty flag; 0 leaves it.
// - In init mode the flag register sits at reset and ignores writes.
// - One empty flag per buffer in bits 2..0; set means empty, unscheduled.
// - Successful transmission of a buffer sets its empty flag.
// - A carried-out abort of a buffer also sets its empty flag.
// - Transmit interrupt stays high while any enabled empty flag is set.
// - Clearing an empty flag also clears that buffer's abort acknowledge.
// - Whenever an empty flag becomes set, its abort request clears.
// - Listen-only mode ignores flag clears and starts no transmission.
// - Buffer access is blocked while its flag is 0 and it is scheduled.
// - Each enable bit 2..0 lets its buffer-empty event raise an interrupt.
// - Interrupt enables sit at reset in init mode, writable only outside.
// - Abort granted only before transmission starts or after a failed try.
// - An abort sets empty flag and abort acknowledge, interrupting if enabled.
// - Software writes never clear an abort request; only hardware does.
// - Abort requests sit at reset in init mode, writable only outside.

`timescale 1ns/100ps
`default_nettype none

module ctb_tx_flags #(
  parameter int unsigned N_BUF = 3
) (
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         reset_n_i,
  // Register port
  input  wire logic [ctb_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [ctb_pkg::DATA_W-1:0]   reg_wdata_i,
  input  wire logic                         reg_wr_i,
  input  wire logic                         reg_rd_i,
  output logic      [ctb_pkg::DATA_W-1:0]   reg_rdata_o,
  // Transmit engine
  input  wire logic [N_BUF-1:0]             tx_busy_i,
  input  wire logic [N_BUF-1:0]             tx_done_i,
  input  wire logic [N_BUF-1:0]             tx_fail_i,
  output logic      [N_BUF-1:0]             tx_req_o,
  output logic      [N_BUF-1:0]             buf_blocked_o,
  // Mode status
  output logic                              init_mode_ack_o,
  // Interrupts
  output logic                              tx_irq_o,
  output logic                              evt_irq_o
);
  import ctb_pkg::*;

  // ==========================================================================
  // Elaboration check
  if (N_BUF < 1 || N_BUF > MAX_BUF) begin : g_bad_n_buf
    $error("N_BUF must lie between 1 and MAX_BUF");
  end

  // ==========================================================================
  // Helpers

  // Zero-extend a buffer vector to a register byte; upper bits read zero
  function automatic logic [DATA_W-1:0] to_byte(input logic [N_BUF-1:0] v);
    logic [DATA_W-1:0] b;
    b = '0;
    b[N_BUF-1:0] = v;
    return b;
  endfunction

  // Write strobe qualified by one register address
  function automatic logic wr_hit(input logic [ADDR_W-1:0] ofs);
    return reg_wr_i && (reg_addr_i == ofs);
  endfunction

  // ==========================================================================
  // State
  logic [N_BUF-1:0] flags_r;        // buf_empty_flag per buffer
  logic [N_BUF-1:0] flags_nxt;
  logic [N_BUF-1:0] ier_r;          // buf_empty_irq_en per buffer
  logic [N_BUF-1:0] arq_r;          // abort_request per buffer
  logic [N_BUF-1:0] arq_nxt;
  logic [N_BUF-1:0] aak_r;          // abort_ack per buffer
  logic [N_BUF-1:0] aak_nxt;
  logic             init_req_r;     // init_mode_request
  logic             init_ack_r;     // init_mode_ack
  logic             listen_r;
  logic [N_BUF-1:0] evt_sent_r;
  logic [N_BUF-1:0] evt_abort_r;
  logic [N_BUF-1:0] evt_sent_en_r;
  logic [N_BUF-1:0] evt_abort_en_r;
  logic [DATA_W-1:0] rdata_r;

  // ==========================================================================
  // Combinational control
  logic             init_active;
  logic [N_BUF-1:0] wdata_buf;
  logic [N_BUF-1:0] clr_req;        // Flags software asks to clear
  logic [N_BUF-1:0] clr_eff;        // Flags that really fall this cycle
  logic [N_BUF-1:0] sent_evt;
  logic [N_BUF-1:0] abort_grant;
  logic [N_BUF-1:0] set_evt;

  assign init_active = init_req_r && init_ack_r;
  assign wdata_buf   = reg_wdata_i[N_BUF-1:0];

  // Write decodes as variables: a continuous assignment would not wake on the
  // strobe read inside the function, so the decode sits in an always_comb
  logic             wr_flags;
  logic             wr_ier;
  logic             wr_arq;
  always_comb begin
    wr_flags = wr_hit(OFS_TX_FLAGS);
    wr_ier   = wr_hit(OFS_TX_IER);
    wr_arq   = wr_hit(OFS_TX_ARQ);
  end

  // Flag clears refused in init and listen-only mode
  assign clr_req = (wr_flags && !init_active && !listen_r) ?
                   wdata_buf : '0;

  // Success only counts for a buffer still queued
  assign sent_evt = tx_done_i & ~flags_r;

  // Abort needs a queued buffer not under way, or whose attempt just failed;
  // a simultaneous success wins, so the message counts as sent anyway
  assign abort_grant = arq_r & ~flags_r & (~tx_busy_i | tx_fail_i) & ~tx_done_i;

  assign set_evt = sent_evt | abort_grant;

  // Hardware set wins over a software clear in the same cycle
  assign clr_eff   = clr_req & flags_r & ~set_evt;
  assign flags_nxt = (flags_r & ~clr_req) | set_evt;

  // Requests are set by software only; a set flag removes them
  assign arq_nxt = (arq_r | (wr_arq ? wdata_buf : '0)) & ~flags_nxt;

  // Acknowledge joins the abort, leaves when the flag is cleared again
  assign aak_nxt = (aak_r | abort_grant) & ~clr_eff;

  // ==========================================================================
  // Mode control: request from software, ack one cycle later
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_req_r <= CTRL_RST[CTRL_INIT_REQ_BIT];
      listen_r   <= CTRL_RST[CTRL_LISTEN_BIT];
      init_ack_r <= 1'b0;
    end else begin
      if (wr_hit(OFS_CTRL)) begin
        init_req_r <= reg_wdata_i[CTRL_INIT_REQ_BIT];
        listen_r   <= reg_wdata_i[CTRL_LISTEN_BIT];
      end
      init_ack_r <= init_req_r;
    end
  end

  // ==========================================================================
  // Empty flags, held at reset during init mode
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= TX_FLAGS_RST[N_BUF-1:0];
    end else if (init_active) begin
      flags_r <= TX_FLAGS_RST[N_BUF-1:0];
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ==========================================================================
  // Interrupt enables
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ier_r <= TX_IER_RST[N_BUF-1:0];
    end else if (init_active) begin
      ier_r <= TX_IER_RST[N_BUF-1:0];
    end else if (wr_hit(OFS_TX_IER)) begin
      ier_r <= wdata_buf;
    end
  end

  // ==========================================================================
  // Abort requests
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      arq_r <= TX_ARQ_RST[N_BUF-1:0];
    end else if (init_active) begin
      arq_r <= TX_ARQ_RST[N_BUF-1:0];
    end else begin
      arq_r <= arq_nxt;
    end
  end

  // ==========================================================================
  // Abort acknowledges
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aak_r <= TX_AAK_RST[N_BUF-1:0];
    end else if (init_active) begin
      aak_r <= TX_AAK_RST[N_BUF-1:0];
    end else begin
      aak_r <= aak_nxt;
    end
  end

  // ==========================================================================
  // Sticky events; set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_sent_r  <= EVT_RST[N_BUF-1:0];
      evt_abort_r <= EVT_RST[N_BUF-1:0];
    end else if (wr_hit(OFS_EVT_CLR)) begin
      evt_sent_r  <= (evt_sent_r & ~reg_wdata_i[EVT_SENT_LSB +: N_BUF]) |
                     (init_active ? '0 : sent_evt);
      evt_abort_r <= (evt_abort_r & ~reg_wdata_i[EVT_ABORT_LSB +: N_BUF]) |
                     (init_active ? '0 : abort_grant);
    end else if (!init_active) begin
      evt_sent_r  <= evt_sent_r | sent_evt;
      evt_abort_r <= evt_abort_r | abort_grant;
    end
  end

  // ==========================================================================
  // Event enables
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      evt_sent_en_r  <= EVT_RST[N_BUF-1:0];
      evt_abort_en_r <= EVT_RST[N_BUF-1:0];
    end else if (wr_hit(OFS_EVT_EN)) begin
      evt_sent_en_r  <= reg_wdata_i[EVT_SENT_LSB +: N_BUF];
      evt_abort_en_r <= reg_wdata_i[EVT_ABORT_LSB +: N_BUF];
    end
  end

  // ==========================================================================
  // Read data: valid only in the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_r <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_TX_FLAGS: rdata_r <= to_byte(flags_r);
        OFS_TX_IER:   rdata_r <= to_byte(ier_r);
        OFS_TX_ARQ:   rdata_r <= to_byte(arq_r);
        OFS_TX_AAK:   rdata_r <= to_byte(aak_r);
        OFS_CTRL: begin
          rdata_r                    <= '0;
          rdata_r[CTRL_INIT_REQ_BIT] <= init_req_r;
          rdata_r[CTRL_LISTEN_BIT]   <= listen_r;
        end
        OFS_STATUS: begin
          rdata_r                    <= '0;
          rdata_r[STAT_INIT_ACK_BIT] <= init_ack_r;
          rdata_r[STAT_INIT_ACT_BIT] <= init_active;
        end
        OFS_EVT_STAT: rdata_r <= to_byte(evt_sent_r) | (to_byte(evt_abort_r) << EVT_ABORT_LSB);
        OFS_EVT_EN:   rdata_r <= to_byte(evt_sent_en_r) |
                                 (to_byte(evt_abort_en_r) << EVT_ABORT_LSB);
        default:      rdata_r <= '0;  // Unmapped and write-only read zero
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata_o     = rdata_r;
  assign init_mode_ack_o = init_ack_r;
  // Queued buffers offered to the engine; none in listen-only or init mode
  assign tx_req_o        = ~flags_r & {N_BUF{!(listen_r || init_active)}};
  // Buffer contents locked while scheduled, so software cannot tear a frame
  assign buf_blocked_o   = ~flags_r;
  // Level request, drops as soon as the flag or its enable goes
  assign tx_irq_o        = |(flags_r & ier_r);
  assign evt_irq_o       = |(evt_sent_r & evt_sent_en_r) | |(evt_abort_r & evt_abort_en_r);

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  // Helper: a clearing write with no competing set
  logic [N_BUF-1:0] clr_only;
  assign clr_only = clr_req & ~set_evt;

  sequence s_abort_granted;
    (|abort_grant) && !init_active;
  endsequence

  sequence s_abort_done;
    ((flags_r & $past(abort_grant)) == $past(abort_grant)) &&
    ((aak_r & $past(abort_grant)) == $past(abort_grant));
  endsequence

  sequence s_listen_on;
    listen_r && !init_active;
  endsequence

  sequence s_no_flag_falls;
    (($past(flags_r) & ~flags_r) == '0);
  endsequence

  a_w1c_clear: assert property (
    (|clr_only) && !init_active |=> ((flags_r & $past(clr_only)) == '0))
    else $error("written-one flag did not clear");

  a_init_hold: assert property (
    init_active |=> (flags_r == TX_FLAGS_RST[N_BUF-1:0]) && (ier_r == '0) && (arq_r == '0))
    else $error("registers not held at reset in init mode");

  a_sent_sets: assert property (
    (|sent_evt) && !init_active |=> ((flags_r & $past(sent_evt)) == $past(sent_evt)))
    else $error("sent buffer not flagged empty");

  a_abort_done: assert property (
    s_abort_granted |=> s_abort_done)
    else $error("aborted buffer lacks empty flag or ack");

  a_irq_level: assert property (
    (|(flags_r & ier_r)) |-> tx_irq_o ##1 (tx_irq_o == |(flags_r & ier_r)))
    else $error("transmit interrupt not following enabled flags");

  a_ack_subset: assert property (
    (aak_r & ~flags_r) == '0)
    else $error("abort ack set on a queued buffer");

  a_arq_drops: assert property (
    (arq_r & flags_r) == '0)
    else $error("abort request left on an empty buffer");

  a_listen_quiet: assert property (
    s_listen_on |-> (tx_req_o == '0) ##1 s_no_flag_falls)
    else $error("flag cleared or transmission offered in listen mode");

  a_abort_gate: assert property (
    $rose(aak_r[0]) |-> (!$past(tx_busy_i[0]) || $past(tx_fail_i[0])))
    else $error("abort granted during a running transmission");

  a_arq_sticky: assert property (
    !init_active |=> ((($past(arq_r) & ~arq_r & ~flags_r) == '0)))
    else $error("abort request lost without the flag setting");

  a_blocked: assert property (
    ~flags_r[0] |-> buf_blocked_o[0] ##1 (buf_blocked_o[0] == ~flags_r[0]))
    else $error("scheduled buffer not blocked");

  a_irq_masked: assert property (
    ((flags_r & ier_r) == '0) |-> !tx_irq_o)
    else $error("transmit interrupt raised with no enabled flag");

  a_ier_write: assert property (
    wr_ier && !init_active |=> (ier_r == $past(wdata_buf)))
    else $error("interrupt enable write outside init mode lost");

  a_arq_write: assert property (
    wr_arq && !init_active |=> (((arq_r | flags_r) & $past(wdata_buf)) == $past(wdata_buf)))
    else $error("abort request write outside init mode lost");

  a_upper_zero: assert property (
    reg_rd_i && ((reg_addr_i == OFS_TX_FLAGS) || (reg_addr_i == OFS_TX_IER) ||
                 (reg_addr_i == OFS_TX_ARQ)) |=> (reg_rdata_o[DATA_W-1:N_BUF] == '0))
    else $error("unused register bits read as one");

  a_flags_rise: assert property (
    !init_active |=> ((flags_r & ~$past(flags_r) & ~$past(set_evt)) == '0))
    else $error("empty flag set without a send or an abort");

  a_evt_sent: assert property (
    (|sent_evt) && !init_active |=> ((evt_sent_r & $past(sent_evt)) == $past(sent_evt)))
    else $error("sent event not recorded");

  a_req_gate: assert property (
    (listen_r || init_active) |-> (tx_req_o == '0))
    else $error("transmission offered in listen or init mode");

endmodule : ctb_tx_flags

`default_nettype wire

//--- ctb_tx_engine_model.sv
// Purpose: Behavioural transmit engine facing the flag block
// Assumes: One clock; serves one queued buffer at a time, lowest first
// Notes:   hold_i keeps it idle, slow_i stretches a frame, fail_i fails it

`timescale 1ns/100ps
`default_nettype none

module ctb_tx_engine_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       reset_n_i,
  // Bench controls
  input  wire logic       hold_i,
  input  wire logic       slow_i,
  input  wire logic       fail_i,
  // Flag block side
  input  wire logic [2:0] tx_req_i,
  output logic      [2:0] tx_busy_o,
  output logic      [2:0] tx_done_o,
  output logic      [2:0] tx_fail_o
);
  logic [3:0] cnt_r;

  // ==========================================================================
  // Frame sequencing
  // One idle cycle after each end pulse, so a stale request is never restarted
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_busy_o <= 3'h0;
      tx_done_o <= 3'h0;
      tx_fail_o <= 3'h0;
      cnt_r     <= 4'h0;
    end else begin
      tx_done_o <= 3'h0;
      tx_fail_o <= 3'h0;
      if (tx_busy_o != 3'h0) begin
        if (cnt_r == 4'h1) begin
          if (fail_i) tx_fail_o <= tx_busy_o;  // Lost arbitration or error
          else tx_done_o <= tx_busy_o;
          tx_busy_o <= 3'h0;
        end
        cnt_r <= cnt_r - 4'h1;
      end else if (!hold_i && tx_req_i != 3'h0 && tx_done_o == 3'h0
                   && tx_fail_o == 3'h0) begin
        tx_busy_o <= tx_req_i & (~tx_req_i + 3'h1);  // Starts only on request
        cnt_r     <= slow_i ? 4'hc : 4'h3;
      end
    end
  end
endmodule // ctb_tx_engine_model

`default_nettype wire

//--- test_can_tx_buffer_flags_abort.sv
// Purpose: Self-checking bench for the transmit flag and abort block
// Assumes: Register reads answer in the cycle after the strobe edge
// Notes:   Random enables and flag clears come from an LFSR seeded at 79

`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end

module test_can_tx_buffer_flags_abort;
  import ctb_pkg::*;

  logic       ref_clk_i = 1'b0;
  logic       reset_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       hold = 1'b1;
  logic       slow = 1'b0;
  logic       fail = 1'b0;
  logic [7:0] rdata;
  logic [2:0] busy, done, failp, req, blocked;
  logic       ack, tx_irq, evt_irq;
  int         num_errors = 0;
  int         checks = 0;
  logic [7:0] seed = 8'd79;
  logic [2:0] flags_exp;

  // ==========================================================================
  // Clock and units
  initial begin
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  ctb_tx_flags #(.N_BUF(3)) i_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .tx_busy_i(busy), .tx_done_i(done), .tx_fail_i(failp), .tx_req_o(req),
    .buf_blocked_o(blocked), .init_mode_ack_o(ack), .tx_irq_o(tx_irq),
    .evt_irq_o(evt_irq));

  ctb_tx_engine_model i_eng (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .hold_i(hold),
    .slow_i(slow), .fail_i(fail), .tx_req_i(req), .tx_busy_o(busy),
    .tx_done_o(done), .tx_fail_o(failp));

  // ==========================================================================
  // Helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Level interrupt expected from flags and enables
  function automatic logic exp_irq(input logic [2:0] f, input logic [7:0] e);
    return |(f & e[2:0]);
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk_i);
    wr    <= 1'b0;
    #1;
  endtask

  // Read data stands only in the cycle after the strobe edge
  task automatic chk_rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge ref_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk_i);
    rd   <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask

  // Bounded wait: sel 1 for engine busy, 0 for buffer flagged empty again
  task automatic wait_on(input bit sel, input logic [2:0] m);
    int k;
    for (k = 0; k < 80; k++) begin
      @(posedge ref_clk_i);
      #1;
      if ((sel ? (busy & m) : (~blocked & m)) != 3'h0) break;
    end
    if (k == 80) begin
      num_errors++;
      $display("BAD wait exp %h got %h", m, blocked);
      print_verdict();
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    chk_rd(OFS_TX_FLAGS, TX_FLAGS_RST, "flags_rst");
    chk_rd(4'hf, 8'h00, "unmapped");
    wr_reg(OFS_TX_FLAGS, 8'h07);
    wr_reg(OFS_TX_IER, 8'h07);
    wr_reg(OFS_TX_ARQ, 8'h07);
    chk_rd(OFS_TX_FLAGS, 8'h07, "flags_init");
    chk_rd(OFS_TX_IER, 8'h00, "ier_init");
    chk_rd(OFS_TX_ARQ, 8'h00, "arq_init");
    wr_reg(OFS_CTRL, 8'h00);
    repeat (3) @(posedge ref_clk_i);
    wr_reg(OFS_TX_IER, 8'hff);
    chk_rd(OFS_TX_IER, 8'h07, "ier_upper");
    `CHK("irq_on", 1'b1, tx_irq)
    wr_reg(OFS_TX_FLAGS, 8'h00);
    chk_rd(OFS_TX_FLAGS, 8'h07, "flags_w0");
    wr_reg(OFS_TX_FLAGS, 8'h01);
    chk_rd(OFS_TX_FLAGS, 8'h06, "flags_w1");
    `CHK("blocked", 3'h1, blocked)
    `CHK("req", 3'h1, req)
    // Abort before the engine starts, then event masking and clearing
    wr_reg(OFS_TX_ARQ, 8'h01);
    chk_rd(OFS_TX_FLAGS, 8'h07, "flags_abort");
    chk_rd(OFS_TX_AAK, 8'h01, "aak_abort");
    chk_rd(OFS_TX_ARQ, 8'h00, "arq_abort");
    chk_rd(OFS_EVT_STAT, 8'h10, "evt_abort");
    `CHK("evt_masked", 1'b0, evt_irq)
    wr_reg(OFS_EVT_EN, 8'h10);
    `CHK("evt_on", 1'b1, evt_irq)
    wr_reg(OFS_EVT_CLR, 8'h10);
    `CHK("evt_clr", 1'b0, evt_irq)
    wr_reg(OFS_TX_FLAGS, 8'h01);
    chk_rd(OFS_TX_AAK, 8'h00, "aak_clr");
    // Plain successful send
    hold <= 1'b0;
    wait_on(1'b0, 3'h1);
    chk_rd(OFS_TX_FLAGS, 8'h07, "flags_sent");
    chk_rd(OFS_TX_AAK, 8'h00, "aak_sent");
    // Abort while sending is not granted; software cannot drop it
    slow <= 1'b1;
    wr_reg(OFS_TX_FLAGS, 8'h02);
    wait_on(1'b1, 3'h2);
    wr_reg(OFS_TX_ARQ, 8'h02);
    wr_reg(OFS_TX_ARQ, 8'h00);
    chk_rd(OFS_TX_ARQ, 8'h02, "arq_held");
    wait_on(1'b0, 3'h2);
    chk_rd(OFS_TX_AAK, 8'h00, "aak_busy");
    chk_rd(OFS_TX_ARQ, 8'h00, "arq_done");
    // Failed attempt lets a pending abort through
    fail <= 1'b1;
    wr_reg(OFS_TX_FLAGS, 8'h04);
    wait_on(1'b1, 3'h4);
    wr_reg(OFS_TX_ARQ, 8'h04);
    wait_on(1'b0, 3'h4);
    chk_rd(OFS_TX_AAK, 8'h04, "aak_fail");
    fail <= 1'b0;
    slow <= 1'b0;
    // Listen-only: clears ignored, a queued buffer is not offered
    hold <= 1'b1;
    wr_reg(OFS_TX_FLAGS, 8'h01);
    wr_reg(OFS_CTRL, 8'h02);
    wr_reg(OFS_TX_FLAGS, 8'h04);
    chk_rd(OFS_TX_FLAGS, 8'h06, "flags_listen");
    `CHK("req_listen", 3'h0, req)
    wr_reg(OFS_CTRL, 8'h00);
    `CHK("req_back", 3'h1, req)
    // Random enables and clears with the engine parked
    flags_exp = 3'h6;
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      wr_reg(OFS_TX_IER, seed);
      #1;
      `CHK("irq_rand", exp_irq(flags_exp, seed), tx_irq)
      seed = lfsr(seed);
      wr_reg(OFS_TX_FLAGS, seed & 8'hfa);
      flags_exp = flags_exp & ~seed[2:0] | (flags_exp & 3'h5 & seed[2:0]);
      chk_rd(OFS_TX_FLAGS, {5'h0, flags_exp}, "flags_rand");
    end
    // Re-entering init mode puts the registers back to reset
    wr_reg(OFS_CTRL, 8'h01);
    repeat (3) @(posedge ref_clk_i);
    chk_rd(OFS_TX_FLAGS, 8'h07, "flags_reinit");
    chk_rd(OFS_TX_IER, 8'h00, "ier_reinit");
    // Sent 0 and 1, aborted 2; events survive init mode
    chk_rd(OFS_EVT_STAT, 8'h43, "evt_sticky");
    // Mid-run reset wipes sticky events as well
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    chk_rd(OFS_EVT_STAT, 8'h00, "evt_rst");
    chk_rd(OFS_TX_FLAGS, TX_FLAGS_RST, "flags_rst2");
    print_verdict();
  end
endmodule // test_can_tx_buffer_flags_abort

`default_nettype wire
